// ---- rtl/cfgpi_pkg.sv ----
// Package: constants and types for the configuration pin interface
package cfgpi_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int ADDR_EXT_W = 4;
    localparam int BYTE_W = 8;
    localparam int MODE_W = 3;
    localparam int PINS_W = 8;
    // ------------------------------------------------------------
    // Mode codes on the three mode pins
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CFGPI_MODE_MSER = 3'h0,
        CFGPI_MODE_DAISY = 3'h1,
        CFGPI_MODE_RSV = 3'h2,
        CFGPI_MODE_PSYNC = 3'h3,
        CFGPI_MODE_MPUP = 3'h4,
        CFGPI_MODE_APER = 3'h5,
        CFGPI_MODE_MPDN = 3'h6,
        CFGPI_MODE_SSER = 3'h7
    } cfgpi_mode_t;
    // ------------------------------------------------------------
    // Reset and start values
    // ------------------------------------------------------------
    localparam logic [21:0] ADDR_UP_START = 22'h00_0000;
    localparam logic [21:0] ADDR_DN_START = 22'h3F_FFFF;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] STATUS_HIGH_BITS = 8'h7F;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
endpackage

// ---- rtl/cfgpi_serial_link.sv ----
// Serial link logic on the configuration clock
`timescale 1ns/1ps
module cfgpi_serial_link (
    input wire logic cfg_clock_i,
    input wire logic rst_n_i,
    input wire logic serial_mode_i,
    input wire logic daisy_mode_i,
    input wire logic daisy_en_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    cfgpi_xfer_if.link xfer
);
    // ------------------------------------------------------------
    // Mode levels synchronised into this domain
    // ------------------------------------------------------------
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic din_q;
    logic fwd_q;
    logic [2:0] bit_cnt;
    logic [7:0] shift;

    // Level crossing of static mode controls
    always_ff @(posedge cfg_clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_s1 <= 3'h0;
            mode_s2 <= 3'h0;
        end else begin
            mode_s1 <= {serial_mode_i, daisy_mode_i, daisy_en_i};
            mode_s2 <= mode_s1;
        end
    end

    // Sample serial input on rising edge; assemble bytes
    always_ff @(posedge cfg_clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            din_q <= 1'b0;
            bit_cnt <= 3'h0;
            shift <= cfgpi_pkg::BYTE_RESET;
            xfer.bit_data <= cfgpi_pkg::BYTE_RESET;
            xfer.bit_tgl <= 1'b0;
            xfer.ack_tgl <= 1'b0;
        end else if (mode_s2[2]) begin
            din_q <= serial_in_i;
            shift <= {shift[6:0], serial_in_i};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == cfgpi_pkg::BIT_CNT_LAST) begin
                // Toggle handoff: one byte per eight clocks is slow enough
                xfer.bit_data <= {shift[6:0], serial_in_i};
                xfer.bit_tgl <= ~xfer.bit_tgl;
            end
        end
    end

    // Forward on the falling edge: 1.5 periods after capture
    always_ff @(negedge cfg_clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fwd_q <= 1'b1;
            serial_out_o <= 1'b1;
            serial_out_oe_o <= 1'b0;
        end else begin
            fwd_q <= din_q;
            if (mode_s2[1]) begin
                serial_out_o <= mode_s2[0];
            end else begin
                serial_out_o <= fwd_q;
            end
            serial_out_oe_o <= 1'b1;
        end
    end
endmodule // cfgpi_serial_link

// ---- rtl/cfgpi_top.sv ----
// Top: configuration-time pin logic of a programmable device
`timescale 1ns/1ps
// Summary of operation
// - Selected only while chip_select_low low and chip_select_high high.
// - Selected write strobe low loads data byte into buffer.
// - Selected read strobe low: bit 7 drives ready status, bits 0-6 high.
// - Both strobes low: write wins, byte is loaded.
// - Byte-daisy mode uses chip_select_high as serial enable.
// - Master parallel drives 18 memory address outputs.
// - Larger master drives 4 extra address outputs.
// - Master parallel modes and peripheral mode APER take bytes on data pins 7-1 plus serial input.
// - Serial modes sample serial input on rising config clock.
// - Master parallel modes and APER use serial input pin as data bit 0.
// - Non-daisy modes drive serial output for next device.
// - Serial output changes on falling edge, 1.5 periods after input.
// - Byte-daisy mode serial output enables downstream chip select.
// - After configuration these pins become user I/O, except serial output, which stays driven.
// - Before configuration done, user I/O pins are weakly pulled high.
module cfgpi_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic cfg_clock_i,
    input wire logic [2:0] mode_i,
    input wire logic config_done_i,
    input wire logic wide_addr_i,
    input wire logic chip_select_low_i,
    input wire logic chip_select_high_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic [7:0] config_byte_in_i,
    input wire logic serial_in_i,
    input wire logic consume_i,
    output logic [7:0] config_byte_out_o,
    output logic config_byte_oe_o,
    output logic [17:0] config_mem_addr_o,
    output logic [3:0] config_mem_addr_ext_o,
    output logic config_mem_addr_oe_o,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic [7:0] cfg_byte_o,
    output logic cfg_byte_valid_o,
    output logic [7:0] user_pullup_en_o,
    output logic user_mode_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    cfgpi_xfer_if xfer ();
    logic [2:0] mode_s1;
    cfgpi_pkg::cfgpi_mode_t mode_q;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic din_s1;
    logic din_s2;
    logic done_s1;
    logic done_s2;
    logic wide_s1;
    logic wide_s2;
    logic wr_prev;
    logic busy;
    logic [7:0] buf_q;
    logic [21:0] addr_q;
    logic fetch_done;
    logic addr_armed;
    logic [2:0] ack_s;
    logic [2:0] bit_s;
    logic selected;
    logic wr_act;
    logic rd_act;
    logic parallel;
    logic master_par;
    logic cfg_active;
    logic [7:0] par_byte;

    // ------------------------------------------------------------
    // Mode decode helpers
    // ------------------------------------------------------------
    function automatic logic is_master_par(input cfgpi_pkg::cfgpi_mode_t m);
        return (m == cfgpi_pkg::CFGPI_MODE_MPUP) || (m == cfgpi_pkg::CFGPI_MODE_MPDN);
    endfunction

    function automatic logic is_parallel(input cfgpi_pkg::cfgpi_mode_t m);
        return is_master_par(m) || (m == cfgpi_pkg::CFGPI_MODE_APER)
            || (m == cfgpi_pkg::CFGPI_MODE_PSYNC);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Selects and strobes: second stage is the only reader of the first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1 <= 4'hB; // Idle: deselected, strobes high
            pin_s2 <= 4'hB;
        end else if (clk_en_i) begin
            pin_s1 <= {chip_select_low_i, chip_select_high_i,
                       write_strobe_n_i, read_strobe_n_i};
            pin_s2 <= pin_s1;
        end
    end

    // Data and serial pins; same depth as the strobes, so data must settle by the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_s1 <= cfgpi_pkg::BYTE_RESET;
            data_s2 <= cfgpi_pkg::BYTE_RESET;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
        end else if (clk_en_i) begin
            data_s1 <= config_byte_in_i;
            data_s2 <= data_s1;
            din_s1 <= serial_in_i;
            din_s2 <= din_s1;
        end
    end

    // Completion level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
        end else if (clk_en_i) begin
            done_s1 <= config_done_i;
            done_s2 <= done_s1;
        end
    end

    // Part size strap
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wide_s1 <= 1'b0;
            wide_s2 <= 1'b0;
        end else if (clk_en_i) begin
            wide_s1 <= wide_addr_i;
            wide_s2 <= wide_s1;
        end
    end

    // Mode pins, first stage; the mode register below is the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_s1 <= 3'h0;
        end else if (clk_en_i) begin
            mode_s1 <= mode_i;
        end
    end

    // Mode latched from its first stage; freezes once done
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= cfgpi_pkg::CFGPI_MODE_MSER;
        end else if (clk_en_i && !done_s2) begin
            mode_q <= cfgpi_pkg::cfgpi_mode_t'(mode_s1);
        end
    end

    // ------------------------------------------------------------
    // Peripheral port decode
    // ------------------------------------------------------------
    assign cfg_active = !done_s2;
    assign parallel = is_parallel(mode_q);
    assign master_par = is_master_par(mode_q);
    assign selected = cfg_active && (mode_q == cfgpi_pkg::CFGPI_MODE_APER)
                      && !pin_s2[3] && pin_s2[2];
    assign wr_act = selected && !pin_s2[1];
    assign rd_act = selected && pin_s2[1] && !pin_s2[0];
    assign par_byte = {data_s2[7:1], din_s2};

    // Buffer load on the write strobe's falling edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_prev <= 1'b0;
            buf_q <= cfgpi_pkg::BYTE_RESET;
            busy <= 1'b0;
        end else if (clk_en_i) begin
            wr_prev <= wr_act;
            if (wr_act && !wr_prev) begin
                buf_q <= par_byte;
                busy <= 1'b1;
            end else if (consume_i) begin
                busy <= 1'b0;
            end
        end
    end

    // Read strobe turns the data pins into a status word
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            config_byte_out_o <= cfgpi_pkg::BYTE_RESET;
            config_byte_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            config_byte_out_o <= {~busy, cfgpi_pkg::STATUS_HIGH_BITS[6:0]};
            config_byte_oe_o <= rd_act;
        end
    end

    // ------------------------------------------------------------
    // Master parallel address generation
    // ------------------------------------------------------------
    // One fetch per consumed byte; up counts from zero, down from top
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_q <= cfgpi_pkg::ADDR_UP_START;
            fetch_done <= 1'b0;
            addr_armed <= 1'b0;
        end else if (clk_en_i) begin
            fetch_done <= 1'b0;
            // Start point loads on the first master cycle: the mode settles after reset
            if (!master_par || !addr_armed) begin
                addr_armed <= master_par;
                addr_q <= (mode_q == cfgpi_pkg::CFGPI_MODE_MPDN) ?
                          cfgpi_pkg::ADDR_DN_START : cfgpi_pkg::ADDR_UP_START;
            end else if (consume_i && cfg_active) begin
                fetch_done <= 1'b1;
                addr_q <= (mode_q == cfgpi_pkg::CFGPI_MODE_MPDN) ?
                          addr_q - 22'h00_0001 : addr_q + 22'h00_0001;
            end
        end
    end

    // Address pins registered; ext bits only on wide parts
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            config_mem_addr_o <= 18'h0_0000;
            config_mem_addr_ext_o <= 4'h0;
            config_mem_addr_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            config_mem_addr_o <= addr_q[17:0];
            config_mem_addr_ext_o <= wide_s2 ? addr_q[21:18] : 4'h0;
            config_mem_addr_oe_o <= master_par && cfg_active;
        end
    end

    // ------------------------------------------------------------
    // Serial link and byte delivery to the core
    // ------------------------------------------------------------
    cfgpi_serial_link u_link (
        .cfg_clock_i(cfg_clock_i),
        .rst_n_i(rst_n_i),
        .serial_mode_i(cfg_active && !parallel),
        .daisy_mode_i(mode_q == cfgpi_pkg::CFGPI_MODE_DAISY),
        .daisy_en_i(pin_s2[2]),
        .serial_in_i(serial_in_i),
        .serial_out_o(serial_out_o),
        .serial_out_oe_o(serial_out_oe_o),
        .xfer(xfer.link)
    );

    // Unused byte path toward the link: toggle held low, data follows the buffer
    assign xfer.byte_data = buf_q;
    assign xfer.byte_tgl = 1'b0;

    // Toggle synchronisers for the link's events
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_s <= 3'h0;
            bit_s <= 3'h0;
        end else if (clk_en_i) begin
            ack_s <= {ack_s[1:0], xfer.ack_tgl};
            bit_s <= {bit_s[1:0], xfer.bit_tgl};
        end
    end

    // Deliver one byte to the configuration core per event
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_byte_o <= cfgpi_pkg::BYTE_RESET;
            cfg_byte_valid_o <= 1'b0;
        end else if (clk_en_i) begin
            cfg_byte_valid_o <= 1'b0;
            if (bit_s[2] != bit_s[1]) begin
                // Data written with the toggle and held for eight link clocks while it lands
                cfg_byte_o <= xfer.bit_data;
                cfg_byte_valid_o <= 1'b1;
            end else if (wr_act && !wr_prev) begin
                cfg_byte_o <= par_byte;
                cfg_byte_valid_o <= 1'b1;
            end else if (fetch_done) begin
                cfg_byte_o <= par_byte;
                cfg_byte_valid_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // User I/O handover
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            user_pullup_en_o <= 8'hFF;
            user_mode_o <= 1'b0;
        end else if (clk_en_i) begin
            user_pullup_en_o <= done_s2 ? 8'h00 : 8'hFF;
            user_mode_o <= done_s2;
        end
    end
endmodule // cfgpi_top

// ---- rtl/cfgpi_xfer_if.sv ----
// Interface: byte and bit crossings between core and link domains
`timescale 1ns/1ps
interface cfgpi_xfer_if;
    logic [7:0] byte_data;
    logic byte_tgl;
    logic ack_tgl;
    logic [7:0] bit_data;
    logic bit_tgl;
    modport core (output byte_data, output byte_tgl, input ack_tgl,
                  input bit_data, input bit_tgl);
    modport link (input byte_data, input byte_tgl, output ack_tgl,
                  output bit_data, output bit_tgl);
endinterface // cfgpi_xfer_if

// ---- verif/cfgpi_serial_src.sv ----
// Serial configuration source: link clock and data, clock only in byte and idle-clock runs
`timescale 1ns/1ps
module cfgpi_serial_src (
    output logic cfg_clock_o,
    output logic serial_in_o
);
    // Clock stands still low between byte and idle-clock runs
    initial begin
        cfg_clock_o = 1'b0;
        serial_in_o = 1'b0;
    end
    // One 15 ns period; data moves mid-low so the rise sees it settled
    task automatic cycle(input logic b);
        serial_in_o = b;
        #3.75 cfg_clock_o = 1'b1;
        #7.5 cfg_clock_o = 1'b0;
        #3.75;
    endtask
    // Byte, most significant bit first
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            cycle(b[i]);
        end
    endtask
    // Idle clocks carry changing data, then the line ends on a fresh level
    task automatic run_clocks(input int n);
        repeat (n) begin
            cycle(~serial_in_o);
        end
        serial_in_o = ~serial_in_o;
    endtask
    // Level of the pin in parallel modes, where it is data bit 0
    task automatic park(input logic v);
        serial_in_o = v;
    endtask
endmodule // cfgpi_serial_src

// ---- verif/cfgpi_top_properties.sv ----
// Checker: timing relations at the configuration pin logic ports
`timescale 1ns/1ps
module cfgpi_top_properties (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cfg_clock_i,
    input wire logic [2:0] mode_i,
    input wire logic wide_addr_i,
    input wire logic chip_select_low_i,
    input wire logic chip_select_high_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic serial_in_i,
    input wire logic consume_i,
    input wire logic [7:0] config_byte_out_o,
    input wire logic config_byte_oe_o,
    input wire logic [3:0] config_mem_addr_ext_o,
    input wire logic config_mem_addr_oe_o,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_o,
    input wire logic cfg_byte_valid_o,
    input wire logic [7:0] user_pullup_en_o,
    input wire logic user_mode_o
);
    // Selected read alone; a write beside it must win, so it is left out
    logic sel_rd;
    logic ser_mode;
    assign sel_rd = !chip_select_low_i && chip_select_high_i
                    && !read_strobe_n_i && write_strobe_n_i;
    assign ser_mode = (mode_i == cfgpi_pkg::CFGPI_MODE_SSER);
    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    property p_oe_cause;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(config_byte_oe_o) |-> $past(sel_rd, 2) || $past(sel_rd, 3);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("read drive without selected read");
    property p_status;
        @(posedge clk_i) disable iff (!rst_n_i)
        config_byte_oe_o |-> config_byte_out_o[6:0] == 7'h7F;
    endproperty
    a_status: assert property (p_status)
        else $error("status low bits not high");
    property p_valid_pulse;
        @(posedge clk_i) disable iff (!rst_n_i)
        cfg_byte_valid_o |=> !cfg_byte_valid_o;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("byte valid longer than one cycle");
    // Status bit lags consume by two edges: busy clears, then the word registers
    property p_busy;
        @(posedge clk_i) disable iff (!rst_n_i)
        config_byte_oe_o && $past(config_byte_oe_o) && !$past(consume_i)
        && !$past(consume_i, 2) && !$past(config_byte_out_o[7]) |-> !config_byte_out_o[7];
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy cleared without consume");
    property p_ready;
        @(posedge clk_i) disable iff (!rst_n_i)
        $past(consume_i, 2) && config_byte_oe_o && $past(config_byte_oe_o)
        |-> config_byte_out_o[7];
    endproperty
    a_ready: assert property (p_ready)
        else $error("not ready after consume");
    // Strap passes two stages and the output register
    property p_ext_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!wide_addr_i) [*4] |-> config_mem_addr_ext_o == 4'h0;
    endproperty
    a_ext_zero: assert property (p_ext_zero)
        else $error("extra address bits on small part");
    property p_user_io;
        @(posedge clk_i) disable iff (!rst_n_i)
        user_mode_o |-> !config_byte_oe_o && !config_mem_addr_oe_o;
    endproperty
    a_user_io: assert property (p_user_io)
        else $error("config pins driven in user mode");
    property p_pullup;
        @(posedge clk_i) disable iff (!rst_n_i)
        !user_mode_o |-> user_pullup_en_o == 8'hFF;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-ups off before done");
    // Link needs two clocks to see the mode, so the first checked bit comes later
    property p_dout;
        @(posedge cfg_clock_i) disable iff (!rst_n_i)
        ser_mode && $past(serial_out_oe_o, 3) |-> serial_out_o == $past(serial_in_i, 2);
    endproperty
    a_dout: assert property (p_dout)
        else $error("serial out not delayed input bit");
endmodule // cfgpi_top_properties
bind cfgpi_top cfgpi_top_properties i_cfgpi_top_properties (
    .clk_i, .rst_n_i, .cfg_clock_i, .mode_i, .wide_addr_i, .chip_select_low_i, .chip_select_high_i,
    .write_strobe_n_i, .read_strobe_n_i, .serial_in_i, .consume_i, .config_byte_out_o,
    .config_byte_oe_o, .config_mem_addr_ext_o, .config_mem_addr_oe_o, .serial_out_o,
    .serial_out_oe_o, .cfg_byte_valid_o, .user_pullup_en_o, .user_mode_o
);

// ---- verif/config_pin_interface_tb.sv ----
// Testbench: configuration pin logic with host and serial source
`timescale 1ns/1ps
module config_pin_interface_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] mode_i = cfgpi_pkg::CFGPI_MODE_APER;
    logic done = 1'b0;
    logic wide = 1'b0;
    logic csl_n = 1'b1;
    logic cs_hi = 1'b0;
    logic wr_n = 1'b1;
    logic rd_n = 1'b1;
    logic cons = 1'b0;
    logic [7:0] din = 8'h00;
    logic cfg_clock, sin, sout, soe, boe, aoe, cval, um;
    logic [7:0] bout, cbyte, pu, last_b;
    logic [17:0] addr;
    logic [3:0] ext;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_val = 0;
    int k;
    // Chip select low, chip select high, loads, byte
    logic [10:0] rows [4] = '{11'h4_A5, 11'h6_5A, 11'h0_C3, 11'h3_3C};
    cfgpi_serial_src i_cfgpi_serial_src (.cfg_clock_o(cfg_clock), .serial_in_o(sin));
    cfgpi_top i_cfgpi_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .cfg_clock_i(cfg_clock),
        .mode_i(mode_i), .config_done_i(done), .wide_addr_i(wide), .chip_select_low_i(csl_n),
        .chip_select_high_i(cs_hi), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n),
        .config_byte_in_i(din), .serial_in_i(sin), .consume_i(cons), .config_byte_out_o(bout),
        .config_byte_oe_o(boe), .config_mem_addr_o(addr), .config_mem_addr_ext_o(ext),
        .config_mem_addr_oe_o(aoe), .serial_out_o(sout), .serial_out_oe_o(soe),
        .cfg_byte_o(cbyte), .cfg_byte_valid_o(cval), .user_pullup_en_o(pu), .user_mode_o(um));
    // Core clock and a count of delivered bytes
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (cval === 1'b1) begin
            n_val <= n_val + 1;
            last_b <= cbyte;
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Reset spans edges of both clocks; mode pins are set meanwhile
    task automatic rst(input logic [2:0] m);
        rst_n_i = 1'b0;
        mode_i = m;
        i_cfgpi_serial_src.run_clocks(3);
        cyc(4);
        check("pull-ups in reset", pu, 8'hFF);
        rst_n_i = 1'b1;
        cyc(6);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            cons = 1'b1;
            cyc(1);
            cons = 1'b0;
            cyc(2);
        end
    endtask
    // Pin bit 0 is the inverse of the serial pin, so the source shows
    task automatic wr(input logic [7:0] b, input logic both);
        din = {b[7:1], ~b[0]};
        i_cfgpi_serial_src.park(b[0]);
        wr_n = 1'b0;
        rd_n = ~both;
        cyc(4);
        if (both) begin
            check("read drive with write", boe, 1'b0);
        end
        wr_n = 1'b1;
        rd_n = 1'b1;
        cyc(4);
    endtask
    task automatic rd_status(input logic sel);
        rd_n = 1'b0;
        cyc(4);
        check("read drive", boe, sel);
        if (sel) begin
            check("busy word", bout, 8'h7F);
            pulse(1);
            check("ready word", bout, 8'hFF);
        end
        rd_n = 1'b1;
        cyc(4);
    endtask
    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    initial begin
        rst(cfgpi_pkg::CFGPI_MODE_APER);
        foreach (rows[i]) begin
            {csl_n, cs_hi} = rows[i][10:9];
            k = n_val;
            wr(rows[i][7:0], 1'b0);
            check("loads", n_val - k, rows[i][8]);
            if (rows[i][8]) begin
                check("byte", last_b, rows[i][7:0]);
            end
            rd_status(rows[i][8]);
        end
        k = n_val;
        wr(8'h96, 1'b1);
        check("both strobes load", n_val - k, 1'b1);
        check("both strobes byte", last_b, 8'h96);
        rd_status(1'b1);
        done = 1'b1;
        cyc(6);
        check("user mode", um, 1'b1);
        check("pull-ups after done", pu, 8'h00);
        k = n_val;
        wr(8'h11, 1'b0);
        check("write after done", n_val - k, 1'b0);
        done = 1'b0;
        rst(cfgpi_pkg::CFGPI_MODE_SSER);
        // Two lead clocks let the link pick up the mode before the frame
        i_cfgpi_serial_src.run_clocks(2);
        k = n_val;
        i_cfgpi_serial_src.send_byte(8'hB4);
        i_cfgpi_serial_src.send_byte(8'h4B);
        i_cfgpi_serial_src.run_clocks(2);
        cyc(6);
        check("serial bytes", n_val - k, 2);
        check("serial byte", last_b, 8'h4B);
        check("serial out drive", soe, 1'b1);
        // Byte-daisy: serial out follows chip_select_high after both crossings
        cs_hi = 1'b1;
        rst(cfgpi_pkg::CFGPI_MODE_DAISY);
        i_cfgpi_serial_src.run_clocks(4);
        check("daisy enable out", sout, 1'b1);
        cyc(1);
        cs_hi = 1'b0;
        cyc(3);
        i_cfgpi_serial_src.run_clocks(4);
        check("daisy disable out", sout, 1'b0);
        rst(cfgpi_pkg::CFGPI_MODE_MPUP);
        check("address drive", aoe, 1'b1);
        check("address start", addr, 18'h0_0000);
        pulse(3);
        check("address up", addr, 18'h0_0003);
        wide = 1'b1;
        rst(cfgpi_pkg::CFGPI_MODE_MPDN);
        check("address top", addr, 18'h3_FFFF);
        check("extra address", ext, 4'hF);
        pulse(1);
        check("address down", addr, 18'h3_FFFE);
        results();
    end
endmodule // config_pin_interface_tb
